// >>> core/lsi_dev_end.sv
// sensor bar end: uart leaves, transmit fifo and the device top with stream and command decoder
// How it works
// R1: stream only while enable pin is low
// R2: controller pulls enable low to request stream
// R3: format 0 sends no stream
// R4: format 1 sends one detection bit per sensor
// R5: sensor 0 in lsb, sensor 7 msb
// R6: format 2 sends position 0-70 or 255
// R7: format 3 sends header then eight raw bytes
// R8: eight parallel pins mirror sensor detection
// R9: frames are 8N1 at selected rate
// R10: baud index 0-5 picks the bit rate
// R11: commands are four bytes in fixed order
// R12: configurable unit address compared with first byte
// R13: foreign address packets are ignored entirely
// R14: checksum is low byte of sum
// R15: nine setting commands decoded with range limits
// R16: accepted setting command answers O then K
// R17: packet dropped after 20 ms byte gap
// R18: a started stream character always completes
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lsi_uart_tx
	import lsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire lsi_div_t div,
	input wire lsi_byte_t tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic txd_r,
	output logic drive_n_r
);
	lsi_tx_st_t state_r;
	logic [8:0] shift_r;
	logic [3:0] bits_r;
	lsi_div_t baud_cnt_r;
	logic bit_end;

	assign tx_ready = (state_r == LSI_TX_IDLE);
	assign bit_end = (baud_cnt_r == div - `LSI_DIV_W'(1));

	// start bit, eight data bits lsb first, one stop bit; a character never aborts once started
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= LSI_TX_IDLE;
			shift_r <= 9'h1FF;
			bits_r <= 4'h0;
			baud_cnt_r <= '0;
			txd_r <= 1'b1;
			drive_n_r <= 1'b1;
		end
		else
		begin
			unique case (state_r)
				LSI_TX_IDLE:
				begin
					if (tx_valid)
					begin
						state_r <= LSI_TX_SEND;
						shift_r <= {1'b1, tx_data}; // see R9
						bits_r <= 4'h0;
						baud_cnt_r <= '0;
						txd_r <= 1'b0;
						drive_n_r <= 1'b0;
					end
				end
				LSI_TX_SEND:
				begin
					baud_cnt_r <= bit_end ? '0 : baud_cnt_r + `LSI_DIV_W'(1);
					if (bit_end)
					begin
						if (bits_r == 4'h9)
						begin
							state_r <= LSI_TX_IDLE; // see R18
							drive_n_r <= 1'b1;
						end
						else
						begin
							txd_r <= shift_r[0];
							shift_r <= {1'b1, shift_r[8:1]};
							bits_r <= bits_r + 4'h1;
						end
					end
				end
			endcase
		end
	end
endmodule : lsi_uart_tx

////////////////////////////////////////////////////////////////////////////////
module lsi_uart_rx
	import lsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire lsi_div_t div,
	input wire logic rxd,
	output lsi_byte_t rx_data_r,
	output logic rx_valid_r
);
	lsi_rx_st_t state_r;
	lsi_div_t cnt_r;
	logic [2:0] bits_r;
	logic half_end;
	logic bit_end;

	assign half_end = (cnt_r == (div >> 1));
	assign bit_end = (cnt_r == div - `LSI_DIV_W'(1));

	// sample mid-bit; a bad start or stop bit drops the character silently
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= LSI_RX_IDLE;
			cnt_r <= '0;
			bits_r <= 3'h0;
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
		end
		else
		begin
			rx_valid_r <= 1'b0;
			cnt_r <= cnt_r + `LSI_DIV_W'(1);
			unique case (state_r)
				LSI_RX_IDLE:
				begin
					cnt_r <= '0;
					if (!rxd)
						state_r <= LSI_RX_START;
				end
				LSI_RX_START:
				begin
					if (half_end)
					begin
						cnt_r <= '0;
						bits_r <= 3'h0;
						state_r <= rxd ? LSI_RX_IDLE : LSI_RX_DATA;
					end
				end
				LSI_RX_DATA:
				begin
					if (bit_end)
					begin
						cnt_r <= '0;
						rx_data_r <= {rxd, rx_data_r[7:1]};
						bits_r <= bits_r + 3'h1;
						if (bits_r == 3'h7)
							state_r <= LSI_RX_STOP;
					end
				end
				LSI_RX_STOP:
				begin
					if (bit_end)
					begin
						state_r <= LSI_RX_IDLE;
						rx_valid_r <= rxd; // see R9
					end
				end
			endcase
		end
	end
endmodule : lsi_uart_rx

////////////////////////////////////////////////////////////////////////////////
module lsi_fifo #(
	parameter int W = `LSI_FIFO_W,
	parameter int D = `LSI_FIFO_D
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_r;
	logic [AW:0] rd_r;

	assign in_ready = (wr_r != {~rd_r[AW], rd_r[AW-1:0]});
	assign out_valid = (wr_r != rd_r);
	assign out_data = mem[rd_r[AW-1:0]];

	// storage carries no reset; only the pointers define what is valid
	always_ff @(posedge clk)
		if (in_valid && in_ready)
			mem[wr_r[AW-1:0]] <= in_data;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_r <= '0;
			rd_r <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_r <= wr_r + (AW+1)'(1);
			if (out_valid && out_ready)
				rd_r <= rd_r + (AW+1)'(1);
		end
	end
endmodule : lsi_fifo

////////////////////////////////////////////////////////////////////////////////
module lsi_dev_end
	import lsi_pkg::*;
#(
	parameter int unsigned PKT_GAP_CYC = `LSI_PKT_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	lsi_if.dev link,
	input wire logic [7:0] sensor_hit,
	input wire lsi_byte_t line_pos,
	input wire logic [63:0] raw_value,
	output logic calibrate_r,
	output logic line_polarity_r,
	output logic [2:0] threshold_r,
	output logic [3:0] junction_width_r,
	output logic [3:0] backlight_r,
	output lsi_byte_t contrast_r,
	output lsi_byte_t unit_address_r,
	output logic [2:0] baud_index_r,
	output logic [1:0] stream_format_r
);
	logic [1:0] rx_sync_r;
	logic [1:0] en_sync_r;
	logic rxd;
	logic en_n;
	logic [7:0] sensor_out_r;
	logic [2:0] baud_live_r;
	logic baud_pend_r;
	lsi_div_t div;
	lsi_byte_t rx_data;
	logic rx_valid;
	logic [1:0] pkt_idx_r;
	lsi_byte_t pkt_addr_r;
	lsi_byte_t pkt_cmd_r;
	lsi_byte_t pkt_data_r;
	logic [`LSI_GAP_W-1:0] gap_cnt_r;
	logic pkt_good;
	logic cmd_ok;
	logic [1:0] reply_cnt_r;
	logic [3:0] raw_idx_r;
	lsi_byte_t stream_byte;
	logic stream_want;
	logic [`LSI_FIFO_W-1:0] fin_data;
	logic fin_valid;
	logic fin_ready;
	logic [`LSI_FIFO_W-1:0] fout_data;
	logic fout_valid;
	logic fout_ready;
	logic drop;
	logic tx_ready;

	// pins cross in through two flops; only the second stage is read
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_sync_r <= 2'h3;
			en_sync_r <= 2'h3;
		end
		else
		begin
			rx_sync_r <= {rx_sync_r[0], link.rx};
			en_sync_r <= {en_sync_r[0], link.stream_output_enable_n}; // see R2
		end
	end
	assign rxd = rx_sync_r[1];
	assign en_n = en_sync_r[1];

	// parallel detection pins, bit n is sensor n
	always_ff @(posedge clk)
		sensor_out_r <= rst ? 8'h00 : sensor_hit; // see R8
	assign link.sensor_out = sensor_out_r;

	// a new rate waits until the reply is out so the OK leaves at the rate it was asked at
	assign div = lsi_baud_div(baud_live_r); // see R10
	always_ff @(posedge clk)
		if (rst)
			baud_live_r <= `LSI_DEF_BAUD;
		else if (baud_pend_r && !fout_valid && tx_ready && reply_cnt_r == 2'h0)
			baud_live_r <= baud_index_r;

	lsi_uart_rx u_rx (.clk(clk), .rst(rst), .div(div), .rxd(rxd), .rx_data_r(rx_data), .rx_valid_r(rx_valid));

	////////////////////////////////////////////////////////////////////////////
	// packet check: address match and checksum on the fourth byte
	assign pkt_good = (pkt_idx_r == 2'h3) && rx_valid && (pkt_addr_r == unit_address_r) // see R12 R13
		&& (rx_data == 8'(pkt_addr_r + pkt_cmd_r + pkt_data_r)); // see R14

	// range check of the data byte per command; anything else is not acted on
	always_comb
	begin
		unique case (pkt_cmd_r) // see R15
			`LSI_CMD_CALIB: cmd_ok = (pkt_data_r == 8'h00);
			`LSI_CMD_POLAR: cmd_ok = (pkt_data_r <= `LSI_POLAR_MAX);
			`LSI_CMD_THRES: cmd_ok = (pkt_data_r <= `LSI_THRES_MAX);
			`LSI_CMD_JWIDTH: cmd_ok = (pkt_data_r >= `LSI_JWIDTH_MIN) && (pkt_data_r <= `LSI_JWIDTH_MAX);
			`LSI_CMD_ADDR: cmd_ok = 1'b1;
			`LSI_CMD_BLIGHT: cmd_ok = (pkt_data_r <= `LSI_BLIGHT_MAX);
			`LSI_CMD_CONTR: cmd_ok = 1'b1;
			`LSI_CMD_BAUD: cmd_ok = (pkt_data_r <= `LSI_BAUD_IDX_MAX);
			`LSI_CMD_FMT: cmd_ok = (pkt_data_r <= `LSI_FMT_MAX);
			default: cmd_ok = 1'b0;
		endcase
	end

	// byte collector with gap timeout; a stale partial packet restarts at the address byte
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pkt_idx_r <= 2'h0;
			pkt_addr_r <= 8'h00;
			pkt_cmd_r <= 8'h00;
			pkt_data_r <= 8'h00;
			gap_cnt_r <= '0;
		end
		else if (rx_valid)
		begin
			gap_cnt_r <= '0;
			pkt_idx_r <= pkt_idx_r + 2'h1; // see R11
			unique case (pkt_idx_r)
				2'h0: pkt_addr_r <= rx_data;
				2'h1: pkt_cmd_r <= rx_data;
				2'h2: pkt_data_r <= rx_data;
				2'h3: pkt_data_r <= pkt_data_r;
			endcase
		end
		else if (pkt_idx_r != 2'h0)
		begin
			gap_cnt_r <= gap_cnt_r + `LSI_GAP_W'(1);
			if (gap_cnt_r >= `LSI_GAP_W'(PKT_GAP_CYC - 1))
			begin
				pkt_idx_r <= 2'h0; // see R17
				gap_cnt_r <= '0;
			end
		end
	end

	// settings update on an accepted command
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			calibrate_r <= 1'b0;
			line_polarity_r <= `LSI_DEF_POLAR;
			threshold_r <= `LSI_DEF_THRES;
			junction_width_r <= `LSI_DEF_JWIDTH;
			backlight_r <= `LSI_DEF_BLIGHT;
			contrast_r <= `LSI_DEF_CONTR;
			unit_address_r <= `LSI_DEF_ADDR;
			baud_index_r <= `LSI_DEF_BAUD;
			baud_pend_r <= 1'b0;
			stream_format_r <= `LSI_DEF_FMT;
		end
		else
		begin
			calibrate_r <= pkt_good && cmd_ok && (pkt_cmd_r == `LSI_CMD_CALIB);
			if (baud_live_r == baud_index_r)
				baud_pend_r <= 1'b0;
			if (pkt_good && cmd_ok)
			begin
				unique case (pkt_cmd_r) // see R15
					`LSI_CMD_POLAR: line_polarity_r <= pkt_data_r[0];
					`LSI_CMD_THRES: threshold_r <= pkt_data_r[2:0];
					`LSI_CMD_JWIDTH: junction_width_r <= pkt_data_r[3:0];
					`LSI_CMD_ADDR: unit_address_r <= pkt_data_r;
					`LSI_CMD_BLIGHT: backlight_r <= pkt_data_r[3:0];
					`LSI_CMD_CONTR: contrast_r <= pkt_data_r;
					`LSI_CMD_BAUD:
					begin
						baud_index_r <= pkt_data_r[2:0];
						baud_pend_r <= 1'b1;
					end
					`LSI_CMD_FMT: stream_format_r <= pkt_data_r[1:0];
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stream byte for the current format
	always_comb
	begin
		unique case (stream_format_r)
			`LSI_FMT_BITS: stream_byte = sensor_hit; // see R4 R5
			`LSI_FMT_POS: stream_byte = (sensor_hit == 8'h00) ? `LSI_POS_NONE // see R6
				: ((line_pos > `LSI_POS_MAX) ? `LSI_POS_MAX : line_pos);
			`LSI_FMT_RAW: stream_byte = (raw_idx_r == 4'h0) ? `LSI_RAW_HDR // see R7
				: raw_value[{raw_idx_r[2:0] - 3'h1, 3'h0} +: 8];
			`LSI_FMT_OFF: stream_byte = 8'h00;
		endcase
	end

	// stream only when asked and enabled; replies take priority over stream bytes
	assign stream_want = !en_n && (stream_format_r != `LSI_FMT_OFF) && !baud_pend_r; // see R1 R3
	assign fin_valid = (reply_cnt_r != 2'h0) || stream_want;
	assign fin_data = (reply_cnt_r == 2'h2) ? {1'b0, `LSI_ASCII_O}
		: (reply_cnt_r == 2'h1) ? {1'b0, `LSI_ASCII_K} : {1'b1, stream_byte};

	// reply counter: a fresh accept reloads even if it lands on a push edge
	always_ff @(posedge clk)
		if (rst)
			reply_cnt_r <= 2'h0;
		else if (pkt_good && cmd_ok)
			reply_cnt_r <= 2'h2; // see R16
		else if (reply_cnt_r != 2'h0 && fin_ready)
			reply_cnt_r <= reply_cnt_r - 2'h1;

	// raw packet position; a stopped stream restarts with the header
	always_ff @(posedge clk)
		if (rst || en_n || stream_format_r != `LSI_FMT_RAW)
			raw_idx_r <= 4'h0;
		else if (reply_cnt_r == 2'h0 && stream_want && fin_ready)
			raw_idx_r <= (raw_idx_r == `LSI_RAW_LAST) ? 4'h0 : raw_idx_r + 4'h1; // see R7

	lsi_fifo #(.W(`LSI_FIFO_W), .D(`LSI_FIFO_D)) u_fifo (.clk(clk), .rst(rst), .in_data(fin_data),
		.in_valid(fin_valid), .in_ready(fin_ready), .out_data(fout_data), .out_valid(fout_valid),
		.out_ready(fout_ready));

	// queued stream bytes are discarded once enable rises; the character on the wire finishes
	assign drop = fout_data[8] && en_n; // see R1 R18
	assign fout_ready = tx_ready || drop;

	lsi_uart_tx u_tx (.clk(clk), .rst(rst), .div(div), .tx_data(fout_data[7:0]),
		.tx_valid(fout_valid && !drop), .tx_ready(tx_ready), .txd_r(link.tx_d), .drive_n_r(link.tx_oe_n));
endmodule : lsi_dev_end

// >>> shared/lsi_regs.svh
// constants of the line sensor serial interface: rates, commands, limits, defaults, host register map
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH

// clock and serial rates
`define LSI_CLK_HZ 100000000
`define LSI_BAUD_0 9600
`define LSI_BAUD_1 19200
`define LSI_BAUD_2 38400
`define LSI_BAUD_3 57600
`define LSI_BAUD_4 115200
`define LSI_BAUD_5 230400
`define LSI_DIV_W 16
`define LSI_BAUD_IDX_MAX 8'h05

// inter-byte gap allowed inside a command packet
`define LSI_PKT_GAP_MS 20
`define LSI_PKT_GAP_CYC (`LSI_CLK_HZ / 1000 * `LSI_PKT_GAP_MS)
`define LSI_GAP_W 21

// command codes
`define LSI_CMD_CALIB 8'h43
`define LSI_CMD_POLAR 8'h4C
`define LSI_CMD_THRES 8'h54
`define LSI_CMD_JWIDTH 8'h4A
`define LSI_CMD_ADDR 8'h41
`define LSI_CMD_BLIGHT 8'h42
`define LSI_CMD_CONTR 8'h53
`define LSI_CMD_BAUD 8'h52
`define LSI_CMD_FMT 8'h44

// data limits
`define LSI_POLAR_MAX 8'h01
`define LSI_THRES_MAX 8'h07
`define LSI_JWIDTH_MIN 8'h03
`define LSI_JWIDTH_MAX 8'h08
`define LSI_BLIGHT_MAX 8'h0A
`define LSI_FMT_MAX 8'h03

// settings after reset
`define LSI_DEF_POLAR 1'h0
`define LSI_DEF_THRES 3'h4
`define LSI_DEF_JWIDTH 4'h5
`define LSI_DEF_ADDR 8'h01
`define LSI_DEF_BAUD 3'h0
`define LSI_DEF_FMT 2'h0
`define LSI_DEF_BLIGHT 4'h2
`define LSI_DEF_CONTR 8'h80

// stream formats and bytes
`define LSI_FMT_OFF 2'h0
`define LSI_FMT_BITS 2'h1
`define LSI_FMT_POS 2'h2
`define LSI_FMT_RAW 2'h3
`define LSI_RAW_HDR 8'h00
`define LSI_RAW_LAST 4'h8
`define LSI_POS_NONE 8'hFF
`define LSI_POS_MAX 8'h46
`define LSI_ASCII_O 8'h4F
`define LSI_ASCII_K 8'h4B

// transmit buffer
`define LSI_FIFO_W 9
`define LSI_FIFO_D 16

// host register map (byte addresses) and fields
`define LSI_REG_CTRL 12'h000
`define LSI_REG_CMD 12'h004
`define LSI_REG_STATUS 12'h008
`define LSI_REG_RXDATA 12'h00C
`define LSI_CTRL_STREAM 0
`define LSI_STAT_BUSY 0
`define LSI_STAT_OK 1
`define LSI_STAT_RXV 2

`endif

// >>> shared/lsi_pkg.sv
// types and baud divisor lookup shared by both ends
`include "lsi_regs.svh"
package lsi_pkg;
	typedef enum logic [1:0] {LSI_RX_IDLE, LSI_RX_START, LSI_RX_DATA, LSI_RX_STOP} lsi_rx_st_t;
	typedef enum logic {LSI_TX_IDLE, LSI_TX_SEND} lsi_tx_st_t;
	typedef logic [7:0] lsi_byte_t;
	typedef logic [`LSI_DIV_W-1:0] lsi_div_t;

	// cycles per bit for a baud index; out-of-range indices fall back to the slowest rate
	function automatic lsi_div_t lsi_baud_div(input logic [2:0] idx);
		unique case (idx)
			3'h1: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_1);
			3'h2: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_2);
			3'h3: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_3);
			3'h4: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_4);
			3'h5: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_5);
			default: lsi_baud_div = `LSI_DIV_W'(`LSI_CLK_HZ / `LSI_BAUD_0);
		endcase
	endfunction : lsi_baud_div
endpackage : lsi_pkg

// >>> shared/lsi_if.sv
// pins between the sensor bar and its controller
`timescale 1ns/1ps
interface lsi_if;
	logic tx_d;
	logic tx_oe_n;
	logic tx_line;
	logic rx;
	logic stream_output_enable_n;
	logic [7:0] sensor_out;

	// tx floats when not driven; the pull-up makes it read idle high
	assign tx_line = tx_oe_n ? 1'b1 : tx_d;

	modport dev (output tx_d, output tx_oe_n, output sensor_out, input rx, input stream_output_enable_n);
	modport host (input tx_line, input sensor_out, output rx, output stream_output_enable_n);
endinterface : lsi_if

// >>> core/lsi_host_end.sv
// controller end: apb registers, packet sender and serial receiver toward the sensor bar
`timescale 1ns/1ps

module lsi_host_end
	import lsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	lsi_if.host link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r
);
	logic [8:0] pin_meta_r;
	logic [8:0] pin_sync_r;
	logic stream_req_r;
	logic [2:0] baud_r;
	logic uen_n_r;
	lsi_div_t div;
	logic [31:0] send_q_r;
	logic [2:0] send_cnt_r;
	logic tx_ready;
	logic txd;
	lsi_byte_t rx_data;
	logic rx_valid;
	lsi_byte_t rx_hold_r;
	logic rx_flag_r;
	logic ok_flag_r;
	logic last_o_r;
	logic acc;
	logic done;
	logic mapped;
	logic [31:0] rd_word;
	lsi_byte_t cmd_sum;

	////////////////////////////////////////////////////////////////////////////
	// serial line and sensor pins cross in through two flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta_r <= 9'h100;
			pin_sync_r <= 9'h100;
		end
		else
		begin
			pin_meta_r <= {link.tx_line, link.sensor_out};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign div = lsi_baud_div(baud_r); // see R10

	// low enable requests the stream, high stops it
	always_ff @(posedge clk)
		uen_n_r <= rst ? 1'b1 : !stream_req_r; // see R2
	assign link.stream_output_enable_n = uen_n_r;

	////////////////////////////////////////////////////////////////////////////
	// apb: access phase takes two cycles, effects land on the completing edge
	assign acc = psel && penable;
	assign done = acc && pready_r;
	assign mapped = (paddr == `LSI_REG_CTRL) || (paddr == `LSI_REG_CMD)
		|| (paddr == `LSI_REG_STATUS) || (paddr == `LSI_REG_RXDATA);
	assign cmd_sum = 8'(pwdata[7:0] + pwdata[15:8] + pwdata[23:16]); // see R14

	always_comb
	begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			`LSI_REG_CTRL: rd_word = {28'h0000000, baud_r, stream_req_r};
			`LSI_REG_CMD: rd_word = {24'h000000, 5'h00, send_cnt_r};
			`LSI_REG_STATUS: rd_word = {16'h0000, pin_sync_r[7:0], 5'h00, rx_flag_r, ok_flag_r,
				(send_cnt_r != 3'h0)};
			`LSI_REG_RXDATA: rd_word = {24'h000000, rx_hold_r};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else
		begin
			pready_r <= acc && !pready_r;
			if (acc && !pready_r)
			begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
				pslverr_r <= !mapped;
			end
		end
	end

	// control register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			stream_req_r <= 1'b0;
			baud_r <= `LSI_DEF_BAUD;
		end
		else if (done && pwrite && paddr == `LSI_REG_CTRL)
		begin
			stream_req_r <= pwdata[`LSI_CTRL_STREAM];
			baud_r <= pwdata[3:1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// packet sender: address, command, data, checksum; a write while busy is dropped
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			send_q_r <= 32'h0000_0000;
			send_cnt_r <= 3'h0;
		end
		else if (done && pwrite && paddr == `LSI_REG_CMD && send_cnt_r == 3'h0)
		begin
			send_q_r <= {cmd_sum, pwdata[23:0]}; // see R11
			send_cnt_r <= 3'h4;
		end
		else if (send_cnt_r != 3'h0 && tx_ready)
		begin
			send_q_r <= {8'h00, send_q_r[31:8]};
			send_cnt_r <= send_cnt_r - 3'h1;
		end
	end

	lsi_uart_tx u_tx (.clk(clk), .rst(rst), .div(div), .tx_data(send_q_r[7:0]),
		.tx_valid(send_cnt_r != 3'h0), .tx_ready(tx_ready), .txd_r(txd), .drive_n_r());
	assign link.rx = txd; // see R9

	lsi_uart_rx u_rx (.clk(clk), .rst(rst), .div(div), .rxd(pin_sync_r[8]), .rx_data_r(rx_data),
		.rx_valid_r(rx_valid));

	// received bytes and the OK detector; a new event beats a clear on the same edge
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_hold_r <= 8'h00;
			rx_flag_r <= 1'b0;
			ok_flag_r <= 1'b0;
			last_o_r <= 1'b0;
		end
		else
		begin
			if (done && !pwrite && paddr == `LSI_REG_RXDATA)
				rx_flag_r <= 1'b0;
			if (done && pwrite && paddr == `LSI_REG_STATUS && pwdata[`LSI_STAT_OK])
				ok_flag_r <= 1'b0;
			if (rx_valid)
			begin
				rx_hold_r <= rx_data;
				rx_flag_r <= 1'b1;
				last_o_r <= (rx_data == `LSI_ASCII_O);
				if (last_o_r && rx_data == `LSI_ASCII_K)
					ok_flag_r <= 1'b1; // see R16
			end
		end
	end
endmodule : lsi_host_end

// >>> verification/lsi_link_props.sv
// checks on the serial link between the sensor bar and its controller
`timescale 1ns/1ps
module lsi_link_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_d,
	input wire logic tx_oe_n,
	input wire logic rx,
	input wire logic stream_output_enable_n
);
	int unsigned low_r, txb_r, rxb_r, enh_r, rxi_r;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// cycle counters; 32 bits cannot wrap within one run
	always_ff @(posedge clk)
	begin
		low_r <= (rst || tx_oe_n) ? 0 : low_r + 1;
		txb_r <= (rst || $changed(tx_d)) ? 0 : txb_r + 1;
		rxb_r <= (rst || $changed(rx)) ? 0 : rxb_r + 1;
		enh_r <= (rst || !stream_output_enable_n) ? 0 : enh_r + 1;
		rxi_r <= (rst || !rx) ? 0 : rxi_r + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// ten bits at the fastest rate take 4340 cycles, so any drive burst lasts that long
	a_char_span: assert property ($rose(tx_oe_n) |-> low_r >= 4300)
		else $error("tx released inside a character");
	a_stop_high: assert property ($rose(tx_oe_n) |-> $past(tx_d))
		else $error("tx released without a high stop bit");
	a_start_low: assert property ($fell(tx_oe_n) |-> ##[0:1] (!tx_d) [*8])
		else $error("no low start bit");
	a_oe_held: assert property ($fell(tx_oe_n) |=> (!tx_oe_n) [*8])
		else $error("tx drive dropped early");
	a_idle_high: assert property (tx_oe_n && $past(tx_oe_n) |-> tx_d)
		else $error("tx data low while idle");
	// bit cells never shorter than the 230400 cell of 434 cycles
	a_tx_bit_width: assert property ($changed(tx_d) && !tx_oe_n && !$past(tx_oe_n) |-> txb_r >= 430)
		else $error("tx bit too short");
	a_rx_bit_width: assert property ($rose(rx) |-> rxb_r >= 430)
		else $error("rx bit too short");
	// with the stream not requested, only a reply to recent rx traffic may start
	a_stream_gated: assert property ($fell(tx_oe_n) && enh_r > 300 |-> rxi_r < 230000)
		else $error("tx started while stream not requested");
endmodule : lsi_link_props

// >>> verification/tb_line_sensor_serial_interface.sv
// self-checking bench: both ends joined over the link, driven through the controller's apb registers
`timescale 1ns/1ps
`include "lsi_regs.svh"
module tb_line_sensor_serial_interface;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready_r, pslverr_r, err, calibrate_r, line_polarity_r;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata_r, rd;
	logic [7:0] sensor_hit = 8'h00, line_pos = 8'h00, contrast_r, unit_address_r, adr;
	logic [63:0] raw_value = 64'h0;
	logic [3:0] junction_width_r, backlight_r;
	logic [2:0] threshold_r, baud_index_r;
	logic [1:0] stream_format_r;
	logic [7:0] mdl [int];
	logic [7:0] exp_q [$];
	int num_errors = 0, cmp_count = 0, cal_cnt = 0;

	lsi_if lsi_if_i ();
	lsi_dev_end #(.PKT_GAP_CYC(200000)) lsi_dev_end_i (.clk(clk), .rst(rst), .link(lsi_if_i.dev),
		.sensor_hit(sensor_hit), .line_pos(line_pos), .raw_value(raw_value), .calibrate_r(calibrate_r),
		.line_polarity_r(line_polarity_r), .threshold_r(threshold_r), .junction_width_r(junction_width_r),
		.backlight_r(backlight_r), .contrast_r(contrast_r), .unit_address_r(unit_address_r),
		.baud_index_r(baud_index_r), .stream_format_r(stream_format_r));
	lsi_host_end lsi_host_end_i (.clk(clk), .rst(rst), .link(lsi_if_i.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
		.pslverr_r(pslverr_r));
	lsi_link_props lsi_link_props_i (.clk(clk), .rst(rst), .tx_d(lsi_if_i.tx_d), .tx_oe_n(lsi_if_i.tx_oe_n),
		.rx(lsi_if_i.rx), .stream_output_enable_n(lsi_if_i.stream_output_enable_n));

	////////////////////////////////////////////////////////////////////////////////
	// clock, calibrate pulse count and a watchdog well past the slow 9600 phase
	always #5 clk = ~clk;
	always @(posedge clk)
		if (calibrate_r === 1'b1)
			cal_cnt++;
	initial
	begin
		#30000000;
		num_errors++;
		complete_run();
	end

	task complete_run();
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; the request stands until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready_r !== 1'b1)
			@(posedge clk);
		rd = prdata_r;
		err = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task poll(input int b, input int lim, output logic hit);
		hit = 1'b0;
		repeat (lim)
		begin
			apb(1'b0, `LSI_REG_STATUS, 32'h0);
			if (rd[b] === 1'b1)
			begin
				hit = 1'b1;
				break;
			end
		end
	endtask : poll

	task chk_set();
		chk({line_polarity_r, threshold_r, junction_width_r, backlight_r, baud_index_r, stream_format_r},
			{mdl[8'h4C][0], mdl[8'h54][2:0], mdl[8'h4A][3:0], mdl[8'h42][3:0], mdl[8'h52][2:0], mdl[8'h44][1:0]});
		chk({contrast_r, unit_address_r}, {mdl[8'h53], mdl[8'h41]});
	endtask : chk_set

	// send one packet; the model takes the value only when a reply is due
	task cmd(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic ok);
		logic hit;
		apb(1'b1, `LSI_REG_CMD, {8'h00, d, c, a});
		poll(`LSI_STAT_OK, (c == 8'h52 && ok) ? 200000 : 8000, hit);
		chk({31'h0, hit}, {31'h0, ok});
		if (ok)
		begin
			if (c != 8'h43)
				mdl[c] = d;
			apb(1'b1, `LSI_REG_STATUS, 32'h2);
			apb(1'b0, `LSI_REG_RXDATA, 32'h0);
			chk(rd[7:0], `LSI_ASCII_K);
		end
		chk_set();
	endtask : cmd

	// request the stream, compare every byte with the model queue, then release
	task stream(input logic [1:0] f);
		logic hit;
		cmd(adr, 8'h44, {6'h00, f}, 1'b1);
		apb(1'b1, `LSI_REG_CTRL, 32'hB);
		if (f == 2'h0)
		begin
			repeat (10000) @(posedge clk);
			apb(1'b0, `LSI_REG_STATUS, 32'h0);
			chk(rd[2], 1'b0);
		end
		while (exp_q.size() > 0)
		begin
			poll(`LSI_STAT_RXV, 3000, hit);
			apb(1'b0, `LSI_REG_RXDATA, 32'h0);
			chk({hit, rd[7:0]}, {1'b1, exp_q.pop_front()});
		end
		apb(1'b1, `LSI_REG_CTRL, 32'hA);
		repeat (5000) @(posedge clk); // a character already on the wire still lands
		apb(1'b0, `LSI_REG_RXDATA, 32'h0);
		$display("stream format %0d done", f);
	endtask : stream

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		int s;
		logic [7:0] h, p;
		logic [63:0] r;
		logic [7:0] tc [14], td [14];
		logic [13:0] tk;
		s = $urandom(32'h795798b1);
		tc = '{8'h4C, 8'h54, 8'h54, 8'h4A, 8'h4A, 8'h42, 8'h42, 8'h53, 8'h43, 8'h43, 8'h50, 8'h44, 8'h4C, 8'h52};
		td = '{8'h01, 8'h07, 8'h08, 8'h08, 8'h02, 8'h0A, 8'h0B, 8'h00, 8'h00, 8'h01, 8'h00, 8'h04, 8'h02, 8'h06};
		tk = 14'b00000110101011;
		td[7] = 8'($urandom);
		mdl[8'h4C] = `LSI_DEF_POLAR;
		mdl[8'h54] = `LSI_DEF_THRES;
		mdl[8'h4A] = `LSI_DEF_JWIDTH;
		mdl[8'h42] = `LSI_DEF_BLIGHT;
		mdl[8'h53] = `LSI_DEF_CONTR;
		mdl[8'h41] = `LSI_DEF_ADDR;
		mdl[8'h52] = `LSI_DEF_BAUD;
		mdl[8'h44] = `LSI_DEF_FMT;
		adr = 8'h01;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk_set();
		sensor_hit <= 8'($urandom);
		repeat (3) @(posedge clk);
		chk(lsi_if_i.sensor_out, sensor_hit);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1);
		cmd(adr, 8'h52, 8'h05, 1'b1);
		repeat (6000) @(posedge clk); // the bar changes rate only after its K has left
		apb(1'b1, `LSI_REG_CTRL, 32'hA);
		for (int i = 0; i < 14; i++)
			cmd(adr, tc[i], td[i], tk[i]);
		chk(cal_cnt, 1);
		h = 8'($urandom_range(255, 2));
		cmd(adr, 8'h41, h, 1'b1);
		cmd(adr, 8'h4C, 8'h00, 1'b0);
		adr = h;
		$display("settings done");
		stream(2'h0);
		h = 8'($urandom) | 8'h01;
		sensor_hit <= h;
		exp_q = '{h, h, h};
		stream(2'h1);
		sensor_hit <= 8'h00;
		exp_q = '{8'hFF, 8'hFF};
		stream(2'h2);
		p = 8'($urandom);
		sensor_hit <= h;
		line_pos <= p;
		exp_q = '{(p > 8'h46) ? 8'h46 : p, (p > 8'h46) ? 8'h46 : p};
		stream(2'h2);
		r = {$urandom, $urandom};
		raw_value <= r;
		exp_q = '{8'h00};
		for (int i = 0; i < 8; i++)
			exp_q.push_back(r[8 * i +: 8]);
		exp_q.push_back(8'h00);
		stream(2'h3);
		complete_run();
	end
endmodule : tb_line_sensor_serial_interface
